// [include/adc_port_pkg.sv]
// Shared constants for the converter serial command port
package adc_port_pkg;
  localparam int OSC_HZ = 2457600;
  localparam int CLK_HZ = 100000000;
  localparam int RESULT_W = 24;
  localparam int CMD_W = 8;
  localparam int IO_LINES = 8;
  // Command codes
  localparam logic [7:0] CMD_READ_RESULT = 8'h01;
  localparam logic [7:0] CMD_CONT_READ = 8'h03;
  localparam logic [7:0] CMD_STOP_CONT = 8'h0F;
  localparam logic [7:0] CMD_SYNC = 8'hFC;
  localparam logic [7:0] CMD_SLEEP = 8'hFD;
  localparam logic [7:0] CMD_SELF_FULL_CAL = 8'hF0;
  localparam logic [7:0] CMD_SELF_OFFSET_CAL = 8'hF1;
  localparam logic [7:0] CMD_SELF_GAIN_CAL = 8'hF2;
  localparam logic [7:0] CMD_SYS_OFFSET_CAL = 8'hF3;
  localparam logic [7:0] CMD_SYS_GAIN_CAL = 8'hF4;
  localparam logic [7:0] CMD_RESET = 8'hFE;
  // Timing in oscillator periods; calibration waits count ready periods
  localparam int T_TRI_MIN_OSC = 6;
  localparam int T_TRI_MAX_OSC = 10;
  localparam int T_SYNC_LAT_OSC = 3;
  localparam int T_TRI_CNT = T_TRI_MAX_OSC - T_SYNC_LAT_OSC - 1;
  localparam int T_CS_HOLD_OSC = 8;
  localparam int T_NEXT_CMD_OSC = 4;
  localparam int T_CAL_SINGLE_RDY = 2;
  localparam int T_CAL_FULL_RDY = 4;
  localparam int T_RESET_WAIT_OSC = 16;
  localparam int T_IN_TO_OUT_OSC = 50;
  localparam int T_CONT_FIRST_OSC = 10;
  localparam int T_UPDATE_OSC = 4;
  localparam int T_SCLK_HALF_OSC = 4;
  localparam int LINK_TIMEOUT_OSC = 16384;

  typedef enum {CLS_PLAIN, CLS_CAL_SINGLE, CLS_CAL_FULL, CLS_RESET} cmd_class_t;

  function automatic cmd_class_t cmdClass(input logic [7:0] c);
    unique case (c)
      CMD_SELF_FULL_CAL: cmdClass = CLS_CAL_FULL;
      CMD_SELF_OFFSET_CAL, CMD_SELF_GAIN_CAL,
      CMD_SYS_OFFSET_CAL, CMD_SYS_GAIN_CAL: cmdClass = CLS_CAL_SINGLE;
      CMD_RESET: cmdClass = CLS_RESET;
      default: cmdClass = CLS_PLAIN;
    endcase
  endfunction : cmdClass
endpackage : adc_port_pkg

// [include/adc_port_if.sv]
// Serial port wires between host and converter
`timescale 1ns/10ps
interface adc_port_if;
  logic sclk;
  logic csN;
  logic dIn;
  logic dOutO;
  logic dOutOeN;
  logic resultReadyN;
  logic powerDownN;
  logic dOut;
  // Undriven line reads high, as if pulled up
  assign dOut = dOutOeN ? 1'b1 : dOutO;
  modport device(input sclk, input csN, input dIn, input powerDownN,
                 output dOutO, output dOutOeN, output resultReadyN);
  modport host(output sclk, output csN, output dIn, output powerDownN,
               input dOut, input resultReadyN);
endinterface : adc_port_if

// [hdl/adc_device_end.sv]
// Converter end of the serial command port
`timescale 1ns/10ps
// Contract
// RQ1: Power-down low halts all device logic; code holds only the oscillator-side link logic and shared lines in reset.
// RQ2: Select low addresses device; high ignores traffic.
// RQ3: Ready output low marks new result.
// RQ4: Select high releases serial output at once.
// RQ5: Output released 6 to 10 periods after.
// RQ6: Host holds select 8 periods after write.
// RQ7: Host waits 4 periods between plain commands.
// RQ8: Host waits 2 or 4 ready periods.
// RQ9: Host waits 16 periods after reset.
// RQ10: Host waits 50 periods before output clocking.
// RQ11: Continuous mode: first edge 10 periods late.
// RQ12: Result invalid 4 periods while updating.
// RQ13: Eight shared digital lines on input pins.
// RQ14: Ready falling edge marks conversion start.
// RQ15: Shift period at least 4; no stretching.
module adc_device_end
  import adc_port_pkg::*;
#(
  parameter int RES_W = RESULT_W,
  parameter int LINES = IO_LINES,
  parameter int TIMEOUT = LINK_TIMEOUT_OSC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic oscIn,
  adc_port_if.device port,
  input wire logic [RES_W-1:0] resultData,
  input wire logic resultValid,
  output logic resultAccept,
  output logic convStart,
  output logic [7:0] cmdCode,
  output logic cmdValid,
  input wire logic [LINES-1:0] ioDir,
  input wire logic [LINES-1:0] ioDrive,
  output logic [LINES-1:0] ioRead,
  input wire logic [LINES-1:0] ioPinIn,
  output logic [LINES-1:0] ioPinOut,
  output logic [LINES-1:0] ioPinOeN
);
  if (RES_W < 8 || RES_W > 32 || LINES < 1 || LINES > 8 || TIMEOUT < 64 || TIMEOUT > 65535) begin : gBad
    $error("adc_device_end: unsupported parameters");
  end

  typedef enum {LS_CMD, LS_SEND} link_state_t;

  // Toggles and flags shared between the processes below
  logic reqTgl_r, ackTgl_r, convTgl_r, cmdTgl_r, readDone_r;
  logic [7:0] cmdByte_r;

  // Osc-domain synchronisers; first stages feed only second stages
  logic rstS1_r, rstS2_r, enS1_r, enS2_r, pdS1_r, pdS2_r;
  logic sclkS1_r, sclkS2_r, sclkS3_r, csS1_r, csS2_r, dInS1_r, dInS2_r;
  logic reqS1_r, reqS2_r, reqS3_r;
  logic [LINES-1:0] dirS1_r, dirS2_r, drvS1_r, drvS2_r;
  always_ff @(posedge oscIn) begin
    {rstS2_r, rstS1_r} <= {rstS1_r, resetn};
    {enS2_r, enS1_r} <= {enS1_r, clkEn};
  end
  always_ff @(posedge oscIn) begin
    if (enS2_r) begin
      {pdS2_r, pdS1_r} <= {pdS1_r, port.powerDownN};
      {sclkS3_r, sclkS2_r, sclkS1_r} <= {sclkS2_r, sclkS1_r, port.sclk};
      {csS2_r, csS1_r} <= {csS1_r, port.csN};
      {dInS2_r, dInS1_r} <= {dInS1_r, port.dIn};
      {reqS3_r, reqS2_r, reqS1_r} <= {reqS2_r, reqS1_r, reqTgl_r};
      {dirS2_r, dirS1_r} <= {dirS1_r, ioDir};
      {drvS2_r, drvS1_r} <= {drvS1_r, ioDrive};
    end
  end

  // Power-down holds the link logic in reset
  logic linkRst;
  assign linkRst = ~rstS2_r | ~pdS2_r; // RQ1

  logic rise, selected, sclkEdge;
  assign rise = sclkS2_r & ~sclkS3_r;
  assign sclkEdge = sclkS2_r ^ sclkS3_r;
  assign selected = ~csS2_r; // RQ2

  // Result hand-over from the user clock; data held until acknowledged
  logic [RES_W-1:0] resHold_r;
  logic ackS1_r, ackS2_r, resultAccept_r;
  logic convS1_r, convS2_r, convS3_r, convStart_r;
  logic cmdS1_r, cmdS2_r, cmdS3_r, cmdValid_r;
  logic [7:0] cmdCode_r;
  logic [LINES-1:0] ioS1_r, ioS2_r, ioRead_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reqTgl_r <= 1'b0;
      resultAccept_r <= 1'b0;
    end else if (clkEn) begin
      resultAccept_r <= (reqTgl_r == ackS2_r) && !(resultValid && resultAccept_r);
      if (resultValid && resultAccept_r) begin
        resHold_r <= resultData;
        reqTgl_r <= ~reqTgl_r;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {ackS2_r, ackS1_r, convS3_r, convS2_r, convS1_r} <= 5'h00;
      {cmdS3_r, cmdS2_r, cmdS1_r, convStart_r, cmdValid_r} <= 5'h00;
      cmdCode_r <= 8'h00;
      ioRead_r <= '0;
    end else if (clkEn) begin
      {ackS2_r, ackS1_r} <= {ackS1_r, ackTgl_r};
      {convS3_r, convS2_r, convS1_r} <= {convS2_r, convS1_r, convTgl_r};
      {cmdS3_r, cmdS2_r, cmdS1_r} <= {cmdS2_r, cmdS1_r, cmdTgl_r};
      {ioS2_r, ioS1_r} <= {ioS1_r, ioPinIn};
      ioRead_r <= ioS2_r; // RQ13
      convStart_r <= convS2_r ^ convS3_r; // RQ14
      cmdValid_r <= cmdS2_r ^ cmdS3_r;
      if (cmdS2_r ^ cmdS3_r) cmdCode_r <= cmdByte_r;
    end
  end

  // Output result register update window
  logic [RES_W-1:0] outReg_r;
  logic [2:0] updCnt_r;
  logic readyN_r, loadPulse_r;
  always_ff @(posedge oscIn) begin
    if (linkRst) begin
      updCnt_r <= 3'h0;
      readyN_r <= 1'b1;
      // Power-down keeps toggle pairs matched so no hand-over is stranded
      ackTgl_r <= rstS2_r ? reqS3_r : 1'b0;
      convTgl_r <= rstS2_r ? convTgl_r : 1'b0;
      loadPulse_r <= 1'b0;
      outReg_r <= '0;
    end else if (enS2_r) begin
      loadPulse_r <= 1'b0;
      if (reqS2_r ^ reqS3_r) begin
        updCnt_r <= 3'(T_UPDATE_OSC);
        readyN_r <= 1'b1; // RQ12
      end else if (updCnt_r == 3'h1) begin
        updCnt_r <= 3'h0;
        outReg_r <= resHold_r;
        ackTgl_r <= reqS3_r;
        readyN_r <= 1'b0; // RQ3
        convTgl_r <= ~convTgl_r; // RQ14
        loadPulse_r <= 1'b1;
      end else if (updCnt_r != 3'h0) begin
        updCnt_r <= updCnt_r - 3'h1;
      end else if (readDone_r) begin
        readyN_r <= 1'b1;
      end
    end
  end

  // Serial engine
  link_state_t linkState;
  logic [4:0] bitCnt_r;
  logic [7:0] shiftIn_r;
  logic [RES_W-1:0] shiftOut_r;
  logic [15:0] sinceEdge_r;
  logic contMode_r, pending_r, oeN_r, dOut_r;
  logic [7:0] nextByte;
  assign nextByte = {shiftIn_r[6:0], dInS2_r};
  always_ff @(posedge oscIn) begin
    if (linkRst) begin
      linkState <= LS_CMD;
      bitCnt_r <= 5'h00;
      shiftIn_r <= 8'h00;
      cmdByte_r <= 8'h00;
      shiftOut_r <= '0;
      sinceEdge_r <= 16'h0000;
      {contMode_r, pending_r, readDone_r} <= 3'h0;
      cmdTgl_r <= rstS2_r ? cmdTgl_r : 1'b0;
      oeN_r <= 1'b1;
      dOut_r <= 1'b0;
    end else if (enS2_r) begin
      readDone_r <= 1'b0;
      // Either edge restarts the count; a read ends on a falling edge
      if (sclkEdge) sinceEdge_r <= 16'h0000; // RQ5
      else if (sinceEdge_r != 16'hFFFF) sinceEdge_r <= sinceEdge_r + 16'h0001;
      if (loadPulse_r && contMode_r) pending_r <= 1'b1;
      if (!oeN_r && linkState == LS_CMD && sinceEdge_r == 16'(T_TRI_CNT)) oeN_r <= 1'b1; // RQ5
      if (!selected) begin
        linkState <= LS_CMD; // RQ2
        bitCnt_r <= 5'h00;
      end else if (bitCnt_r != 5'h00 && sinceEdge_r == 16'(TIMEOUT)) begin
        linkState <= LS_CMD; // RQ15
        bitCnt_r <= 5'h00;
      end else if (linkState == LS_CMD && bitCnt_r == 5'h00 && pending_r && !loadPulse_r) begin
        pending_r <= 1'b0;
        shiftOut_r <= outReg_r;
        linkState <= LS_SEND;
      end else if (rise) begin
        unique case (linkState)
          LS_CMD: begin
            shiftIn_r <= nextByte;
            bitCnt_r <= bitCnt_r + 5'h01;
            if (bitCnt_r == 5'h07) begin
              bitCnt_r <= 5'h00;
              cmdByte_r <= nextByte;
              cmdTgl_r <= ~cmdTgl_r;
              if (nextByte == CMD_READ_RESULT) begin
                shiftOut_r <= outReg_r;
                linkState <= LS_SEND;
              end
              if (nextByte == CMD_CONT_READ) contMode_r <= 1'b1;
              if (nextByte == CMD_STOP_CONT || nextByte == CMD_RESET) begin
                contMode_r <= 1'b0;
                pending_r <= 1'b0;
              end
            end
          end
          LS_SEND: begin
            dOut_r <= shiftOut_r[RES_W-1];
            shiftOut_r <= {shiftOut_r[RES_W-2:0], 1'b0};
            oeN_r <= 1'b0;
            bitCnt_r <= bitCnt_r + 5'h01;
            if (bitCnt_r == 5'(RES_W - 1)) begin
              bitCnt_r <= 5'h00;
              linkState <= LS_CMD;
              readDone_r <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Shared lines follow user direction and level; released in power-down
  logic [LINES-1:0] ioOut_r, ioOeN_r;
  always_ff @(posedge oscIn) begin
    if (linkRst) begin
      ioOut_r <= '0;
      ioOeN_r <= '1;
    end else if (enS2_r) begin
      ioOut_r <= drvS2_r;
      ioOeN_r <= ~dirS2_r; // RQ13
    end
  end

  // Raw select gates the enable so release needs no clock edge
  assign port.dOutOeN = oeN_r | port.csN; // RQ4
  assign port.dOutO = dOut_r;
  assign port.resultReadyN = readyN_r;
  assign resultAccept = resultAccept_r;
  assign convStart = convStart_r;
  assign cmdCode = cmdCode_r;
  assign cmdValid = cmdValid_r;
  assign ioRead = ioRead_r;
  assign ioPinOut = ioOut_r;
  assign ioPinOeN = ioOeN_r;
endmodule : adc_device_end

// [hdl/adc_host_end.sv]
// Host end of the converter serial command port
`timescale 1ns/10ps
module adc_host_end
  import adc_port_pkg::*;
#(
  parameter int OSC_FREQ = OSC_HZ,
  parameter int RES_W = RESULT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  adc_port_if.host port,
  input wire logic [7:0] cmdCode,
  input wire logic cmdValid,
  output logic cmdReady,
  output logic [RES_W-1:0] resultData,
  output logic resultValid,
  output logic contActive,
  input wire logic powerDownReq
);
  if (OSC_FREQ < 1000 || OSC_FREQ > CLK_HZ / 2 || RES_W < 8 || RES_W > 32) begin : gBad
    $error("adc_host_end: unsupported parameters");
  end

  // Oscillator periods to clk cycles, rounded up
  function automatic int oscCycles(input int n);
    longint num;
    longint den;
    num = longint'(n) * longint'(CLK_HZ);
    den = longint'(OSC_FREQ);
    oscCycles = int'((num + den - 1) / den);
  endfunction : oscCycles

  localparam int HALF = oscCycles(T_SCLK_HALF_OSC);
  localparam int HOLD = oscCycles(T_CS_HOLD_OSC);
  localparam int GAP_OUT = oscCycles(T_IN_TO_OUT_OSC);
  localparam int CONT_FIRST = oscCycles(T_CONT_FIRST_OSC);
  localparam int NEXT_CMD = oscCycles(T_NEXT_CMD_OSC);
  localparam int RESET_WAIT = oscCycles(T_RESET_WAIT_OSC);

  typedef enum {H_IDLE, H_GAP, H_SHIFT, H_HOLD, H_WAIT} host_state_t;
  host_state_t state;

  logic doutS1_r, doutS2_r, rdyS1_r, rdyS2_r, rdyS3_r;
  logic readyFall;
  always_ff @(posedge clk) begin
    if (clkEn) begin
      {doutS2_r, doutS1_r} <= {doutS1_r, port.dOut};
      {rdyS3_r, rdyS2_r, rdyS1_r} <= {rdyS2_r, rdyS1_r, port.resultReadyN};
    end
  end
  assign readyFall = rdyS3_r & ~rdyS2_r;

  logic sclk_r, csN_r, dIn_r, pdN_r, cmdReady_r, resultValid_r, contActive_r, reading_r;
  logic [31:0] timer_r;
  logic [5:0] bitsLeft_r;
  logic [2:0] calLeft_r;
  logic [7:0] cmd_r, tx_r;
  logic [RES_W-1:0] rx_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= H_IDLE;
      {sclk_r, dIn_r, reading_r, resultValid_r, contActive_r} <= 5'h00;
      {csN_r, pdN_r, cmdReady_r} <= 3'h7;
      timer_r <= 32'h0;
      bitsLeft_r <= 6'h00;
      calLeft_r <= 3'h0;
      cmd_r <= 8'h00;
      tx_r <= 8'h00;
      rx_r <= '0;
    end else if (clkEn) begin
      resultValid_r <= 1'b0;
      pdN_r <= ~powerDownReq; // RQ1
      if (timer_r != 32'h0) timer_r <= timer_r - 32'h1;
      unique case (state)
        H_IDLE: begin
          if (contActive_r && readyFall) begin
            csN_r <= 1'b0; // RQ2
            reading_r <= 1'b1;
            bitsLeft_r <= 6'(RES_W);
            timer_r <= 32'(CONT_FIRST); // RQ11
            cmdReady_r <= 1'b0;
            state <= H_GAP;
          end else if (cmdValid && cmdReady_r) begin
            csN_r <= 1'b0; // RQ2
            cmd_r <= cmdCode;
            dIn_r <= cmdCode[7];
            tx_r <= {cmdCode[6:0], 1'b0};
            reading_r <= 1'b0;
            bitsLeft_r <= 6'h08;
            timer_r <= 32'(HALF);
            cmdReady_r <= 1'b0;
            state <= H_SHIFT;
          end
        end
        H_GAP: if (timer_r == 32'h0) begin
          timer_r <= 32'(HALF);
          state <= H_SHIFT;
        end
        H_SHIFT: if (timer_r == 32'h0) begin
          timer_r <= 32'(HALF); // RQ15
          if (!sclk_r) begin
            sclk_r <= 1'b1;
          end else begin
            sclk_r <= 1'b0;
            dIn_r <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
            if (reading_r) rx_r <= {rx_r[RES_W-2:0], doutS2_r};
            bitsLeft_r <= bitsLeft_r - 6'h01;
            if (bitsLeft_r == 6'h01) begin
              if (!reading_r && cmd_r == CMD_READ_RESULT) begin
                reading_r <= 1'b1;
                bitsLeft_r <= 6'(RES_W);
                timer_r <= 32'(GAP_OUT); // RQ10
                state <= H_GAP;
              end else begin
                timer_r <= 32'(HOLD); // RQ6
                state <= H_HOLD;
              end
            end
          end
        end
        H_HOLD: if (timer_r == 32'h0) begin
          csN_r <= 1'b1;
          if (reading_r) begin
            resultValid_r <= 1'b1;
            timer_r <= 32'(NEXT_CMD); // RQ7
            calLeft_r <= 3'h0;
          end else begin
            if (cmd_r == CMD_CONT_READ) contActive_r <= 1'b1;
            if (cmd_r == CMD_STOP_CONT || cmd_r == CMD_RESET) contActive_r <= 1'b0;
            unique case (cmdClass(cmd_r))
              CLS_RESET: timer_r <= 32'(RESET_WAIT); // RQ9
              CLS_CAL_SINGLE: calLeft_r <= 3'(T_CAL_SINGLE_RDY); // RQ8
              CLS_CAL_FULL: calLeft_r <= 3'(T_CAL_FULL_RDY); // RQ8
              CLS_PLAIN: timer_r <= 32'(NEXT_CMD); // RQ7
            endcase
          end
          state <= H_WAIT;
        end
        H_WAIT: begin
          if (readyFall && calLeft_r != 3'h0) calLeft_r <= calLeft_r - 3'h1;
          if (timer_r == 32'h0 && calLeft_r == 3'h0) begin
            cmdReady_r <= 1'b1;
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Result held until the next read completes
  always_ff @(posedge clk) begin
    if (!resetn) resultData <= '0;
    else if (clkEn && state == H_HOLD && timer_r == 32'h0 && reading_r) resultData <= rx_r; // RQ12
  end

  assign port.sclk = sclk_r;
  assign port.csN = csN_r;
  assign port.dIn = dIn_r;
  assign port.powerDownN = pdN_r;
  assign cmdReady = cmdReady_r;
  assign resultValid = resultValid_r;
  assign contActive = contActive_r;
endmodule : adc_host_end

// [testbench/adc_port_properties.sv]
// Link-side checks for the converter serial command port
`timescale 1ns/10ps
module adc_port_properties (
  input wire logic oscIn,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic csN,
  input wire logic dOutOeN,
  input wire logic resultReadyN,
  input wire logic powerDownN,
  input wire logic dOut
);
  default clocking @(posedge oscIn); endclocking
  default disable iff (!resetn);

  // Power-down passes a two-stage sync before the link logic is held
  sequence pdHeld;
    !powerDownN [*5];
  endsequence
  sequence driveFall;
    $fell(sclk) && !dOutOeN;
  endsequence
  sequence lastDriven;
    driveFall ##1 (!sclk) [*8];
  endsequence

  powerHalt_a: assert property (pdHeld |-> dOutOeN && resultReadyN)
    else $error("Output or ready active while powered down");
  wakeQuiet_a: assert property ($rose(powerDownN) |-> resultReadyN && dOutOeN)
    else $error("Output or ready active at wake");
  deselectIdle_a: assert property (csN |-> dOut)
    else $error("Serial output driven while deselected");
  releaseAtOnce_a: assert property ($rose(csN) |-> dOutOeN)
    else $error("Serial output not released on deselect");
  releaseNotEarly_a: assert property (driveFall |-> (csN || !powerDownN || !dOutOeN) [*6])
    else $error("Serial output released too early");
  // Slack of two samples covers the unsynchronised view of the shift clock
  releaseLate_a: assert property (lastDriven |-> ##[0:2] dOutOeN)
    else $error("Serial output released too late");
  readyHold_a: assert property ($fell(resultReadyN) |-> !resultReadyN [*8])
    else $error("Ready low too short");
  updateWindow_a: assert property ($rose(resultReadyN) |-> resultReadyN [*4])
    else $error("Ready low during result update");
endmodule : adc_port_properties

// [testbench/test_adc_serial_command_port.sv]
// Self-checking bench joining host end and converter end
`timescale 1ns/10ps
module test_adc_serial_command_port;
  import adc_port_pkg::*;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic oscIn = 1'b0;
  logic resetn = 1'b0;
  logic [23:0] devData = 24'h000000;
  logic devValid = 1'b0;
  logic devAccept, convStart, devCmdValid, hostReady, hostValid, contActive;
  logic [7:0] devCode;
  logic [7:0] hostCode = 8'h00;
  logic hostCmdValid = 1'b0;
  logic powerDownReq = 1'b0;
  logic [23:0] hostData;
  logic [7:0] ioDir = 8'h00;
  logic [7:0] ioDrive = 8'hC3;
  logic [7:0] ioExt = 8'h3C;
  logic [7:0] ioRead, ioPinOut, ioPinOeN, ioPinIn;
  logic loadReq = 1'b0;
  logic feed = 1'b0;
  int feedGap = 0;
  logic [23:0] gotData = 24'h000000;
  logic [7:0] gotCode = 8'h00;
  logic [7:0] plain [3] = '{CMD_SYNC, CMD_SLEEP, CMD_RESET};
  logic [7:0] cals [5] = '{CMD_SELF_FULL_CAL, CMD_SELF_OFFSET_CAL, CMD_SELF_GAIN_CAL, CMD_SYS_OFFSET_CAL,
    CMD_SYS_GAIN_CAL};
  int gotCnt = 0;
  int convCnt = 0;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;

  adc_port_if port ();
  assign ioPinIn = (~ioPinOeN & ioPinOut) | (ioPinOeN & ioExt);

  adc_device_end #(.TIMEOUT(256)) adc_device_end_inst (.clk(clk), .resetn(resetn), .clkEn(1'b1),
    .oscIn(oscIn), .port(port), .resultData(devData), .resultValid(devValid), .resultAccept(devAccept),
    .convStart(convStart), .cmdCode(devCode), .cmdValid(devCmdValid), .ioDir(ioDir), .ioDrive(ioDrive),
    .ioRead(ioRead), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut), .ioPinOeN(ioPinOeN));
  // Fast oscillator figure keeps the host's link counts short
  adc_host_end #(.OSC_FREQ(83333333)) adc_host_end_inst (.clk(clk), .resetn(resetn), .clkEn(1'b1),
    .port(port), .cmdCode(hostCode), .cmdValid(hostCmdValid), .cmdReady(hostReady), .resultData(hostData),
    .resultValid(hostValid), .contActive(contActive), .powerDownReq(powerDownReq));
  adc_port_properties adc_port_properties_inst (.oscIn(oscIn), .resetn(resetn), .sclk(port.sclk),
    .csN(port.csN), .dOutOeN(port.dOutOeN), .resultReadyN(port.resultReadyN), .powerDownN(port.powerDownN),
    .dOut(port.dOut));

  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #3.7;
    forever #6 oscIn = ~oscIn;
  end

  always @(posedge clk) begin
    if (hostValid === 1'b1) begin
      gotData <= hostData;
      gotCnt <= gotCnt + 1;
    end
    if (devCmdValid === 1'b1) gotCode <= devCode;
    if (convStart === 1'b1) convCnt <= convCnt + 1;
  end

  // One pulse per free slot; spacing keeps each ready low well over the eight periods readyHold_a checks
  always @(posedge clk) begin
    #1;
    devValid = (feed || loadReq) && devAccept === 1'b1 && !devValid && feedGap == 0;
    if (devValid) begin
      loadReq = 1'b0;
      feedGap = 40;
    end else if (feedGap > 0) begin
      feedGap--;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      $display("Error run_cycles expected %0d seen %0d", LIMIT - 1, cycles);
      error_cnt++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic sendCmd(input logic [7:0] code);
    for (int i = 0; i < 20000 && hostReady !== 1'b1; i++) tick(1);
    hostCode = code;
    hostCmdValid = 1'b1;
    tick(1);
    hostCmdValid = 1'b0;
    for (int i = 0; i < 40000 && hostReady !== 1'b1; i++) tick(1);
    tick(4);
  endtask : sendCmd

  task automatic wrap_up();
    $display("Comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    logic [7:0] dir;
    repeat (8) @(posedge clk);
    #1;
    resetn = 1'b1;
    tick(4);
    chk("ready_idle", 24'h000001, {23'h0, port.resultReadyN});
    chk("dout_idle", 24'h000001, {23'h0, port.dOut});
    devData = 24'hA5C3F1;
    loadReq = 1'b1;
    for (int i = 0; i < 2000 && port.resultReadyN !== 1'b0; i++) tick(1);
    chk("ready_low", 24'h000000, {23'h0, port.resultReadyN});
    tick(10);
    chk("conv_start", 24'h000001, 24'(convCnt));
    sendCmd(CMD_READ_RESULT);
    chk("read_code", {16'h0, CMD_READ_RESULT}, {16'h0, gotCode});
    chk("read_data", 24'hA5C3F1, gotData);
    chk("ready_after_read", 24'h000001, {23'h0, port.resultReadyN});
    foreach (plain[k]) begin
      sendCmd(plain[k]);
      chk("plain_code", {16'h0, plain[k]}, {16'h0, gotCode});
    end
    sendCmd(CMD_CONT_READ);
    chk("cont_on", 24'h000001, {23'h0, contActive});
    devData = 24'h3C0F96;
    loadReq = 1'b1;
    for (int i = 0; i < 30000 && gotCnt < 2; i++) tick(1);
    chk("cont_data", 24'h3C0F96, gotData);
    sendCmd(CMD_STOP_CONT);
    chk("cont_off", 24'h000000, {23'h0, contActive});
    // Calibration waits count ready periods, so results keep arriving
    feed = 1'b1;
    foreach (cals[k]) begin
      sendCmd(cals[k]);
      chk("cal_code", {16'h0, cals[k]}, {16'h0, gotCode});
    end
    feed = 1'b0;
    tick(100);
    powerDownReq = 1'b1;
    tick(20);
    chk("pd_pin", 24'h000000, {23'h0, port.powerDownN});
    chk("pd_ready", 24'h000001, {23'h0, port.resultReadyN});
    chk("pd_dout", 24'h000001, {23'h0, port.dOut});
    powerDownReq = 1'b0;
    tick(50);
    for (int k = 0; k < 8; k++) begin
      dir = 8'h01 << k;
      ioDir = dir;
      tick(10);
      chk("io_read", {16'h0, (dir & ioDrive) | (~dir & ioExt)}, {16'h0, ioRead});
      chk("io_oe", {16'h0, ~dir}, {16'h0, ioPinOeN});
    end
    devData = 24'h5A0F3C;
    loadReq = 1'b1;
    for (int i = 0; i < 2000 && port.resultReadyN !== 1'b0; i++) tick(1);
    chk("wake_ready", 24'h000000, {23'h0, port.resultReadyN});
    sendCmd(CMD_READ_RESULT);
    chk("wake_data", 24'h5A0F3C, gotData);
    wrap_up();
  end
endmodule : test_adc_serial_command_port
